// ===== dv/e1_slot0_spare_bit_and_pll_config_bench.sv
// testbench of the spare-bit and pll configuration block
// assumes esb_pkg compiled first and the line model beside the block
`timescale 1ns/1ps
module e1_slot0_spare_bit_and_pll_config_bench;
  import esb_pkg::*;
  logic       mclk, rst, wr, rd, pin, rclk, par, pay, odd, skp, slp, slost, eover;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, c;
  logic       fz, xt, pref, rco, rcoe, nomf, lca, odis, tfr, szi, s6i;
  logic       mck, mfr, mdi, mdo, moe, rss, rms, tk;
  logic [4:0] rsa, tsa;
  logic [3:0] rs6, ts6;
  logic [7:0] rv [4] = '{8'h80, 8'h80, 8'h80, 8'hff};
  logic [7:0] cv [2] = '{8'hfb, 8'h80};
  int         miscompares, total_checks, cycles, szn, s6n, n;
  esb_top #(.STORE_CYC(50)) dut
  (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pll_input_pin(pin), .recovered_clock(rclk), .pll_freeze(fz), .pll_ref_crystal(xt),
    .pll_ref(pref), .recovered_clock_out(rco), .recovered_clock_out_oe(rcoe),
    .no_multiframe(nomf), .line_code_ami(lca), .oscillator_disable(odis),
    .mux_clk(mck), .mux_frame(mfr), .mux_din(mdi), .parallel_host(par), .payload_bit(pay),
    .frame_odd(odd), .skip_flag(skp), .slip_flag(slp), .sync_lost(slost), .err_over(eover),
    .mux_dout(mdo), .mux_dout_oe(moe), .rx_sa_strobe(rss), .rx_sa(rsa),
    .rx_smf_strobe(rms), .rx_sa6(rs6), .tx_smf_take(tk), .tx_sa(tsa), .tx_sa6(ts6),
    .tx_sa6_from_reg(tfr), .slot_zero_interrupt(szi), .sa6_interrupt(s6i)
  );
  esb_line_model line
  (
    .mclk(mclk), .mux_clk(mck), .mux_frame(mfr), .mux_din(mdi), .mux_dout(mdo),
    .mux_dout_oe(moe), .rx_sa_strobe(rss), .rx_sa(rsa), .rx_smf_strobe(rms),
    .rx_sa6(rs6), .tx_smf_take(tk)
  );
  // 100 MHz core clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // interrupt pulses are counted; a hang is cut short
  always @(posedge mclk)
  begin
    szn    <= szn + int'(szi === 1'b1);
    s6n    <= s6n + int'(s6i === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic compare(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : compare
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wreg
  // read one register, compare the masked data in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    compare($sformatf("reg %h", a), e, rdata & m);
  endtask : rchk
  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask : settle
  // wait for two whole frames, then judge slot zero on the bus
  task automatic slot(input string w, input logic [7:0] e, input logic [7:0] eo,
                      input logic [7:0] m);
    n = line.frames;
    while (line.frames < n + 2)
      @(posedge mclk);
    compare(w, e, line.cap_dout & m);
    compare({w, " oe"}, eo, line.cap_oe);
  endtask : slot
  // same new spare bits in k received frames
  task automatic rxn(input logic [4:0] v, input int k);
    repeat (k) line.rx_frame(v);
    settle();
  endtask : rxn
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    rst = 1'b1;
    {wr, rd, pin, rclk, par, pay, odd, skp, slp, slost, eover} = '0;
    {addr, wdata} = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    foreach (rv[i]) rchk(4'(i), 8'hff, rv[i]);
    wreg(4'h9, 8'h5a);
    rchk(4'h9, 8'hff, 8'h00);
    foreach (cv[i])
    begin
      wreg(REG_PLL, cv[i]);
      wreg(REG_RTLO, cv[i] & 8'ha0);
      wreg(REG_RTHI, cv[i] & 8'hc0);
      settle();
      compare("freeze", cv[i][0], fz);
      compare("crystal", cv[i][1], xt);
      compare("hcr oe", !cv[i][3], rcoe);
      compare("no mf", cv[i][4], nomf);
      compare("ami", cv[i][6], lca);
      compare("osc", cv[i][5], odis);
    end
    rclk <= 1'b1;
    settle();
    compare("ref rec", 1'b1, pref);
    compare("hcr copy", 1'b1, rco);
    wreg(REG_PLL, 8'h84);
    settle();
    compare("ref pin", 1'b0, pref);
    par <= 1'b1;
    wreg(REG_PLL, 8'h80);
    slot("float", 8'h00, 8'h00, 8'h00);
    wreg(REG_PLL, 8'hc0);
    {odd, skp, slp} <= 3'b101;
    slot("flags", 8'h05, 8'hff, 8'h07);
    {odd, skp, slp} <= 3'b010;
    slot("flags", 8'h02, 8'hff, 8'h07);
    slost <= 1'b1;
    slot("lost", 8'hff, 8'hff, 8'hff);
    {slost, eover} <= 2'b01;
    slot("errors", 8'hff, 8'hff, 8'hff);
    eover <= 1'b0;
    wreg(REG_PLL, 8'he0);
    slot("alarm", 8'h00, 8'hff, 8'h00);
    c = line.cap_dout;
    compare("alarm", 8'h7f, {1'b0, c[7:1] ^ c[6:0]});
    wreg(REG_PLL, 8'hc0);
    line.din_byte = 8'hb5;
    wreg(REG_RTLO, 8'h85);
    wreg(REG_RTHI, 8'h95);
    slot("route", 8'h00, 8'hff, 8'h00);
    compare("tx pins", 8'h16, tsa);
    wreg(REG_RTLO, 8'h80);
    wreg(REG_RTHI, 8'h80);
    wreg(REG_TXSA, 8'h0d);
    settle();
    compare("tx regs", 8'h0d, tsa);
    wreg(REG_RTHI, 8'h82);
    wreg(REG_S6TX, 8'h09);
    settle();
    compare("sa6 src", 1'b1, tfr);
    compare("sa6 tx", 8'h09, ts6);
    rchk(REG_S6TX, 8'h80, 8'h80);
    line.tx_take();
    rchk(REG_S6TX, 8'h80, 8'h00);
    wreg(REG_RTLO, 8'h90);
    wreg(REG_S6TX, 8'h06);
    repeat (2) line.tx_take();
    rchk(REG_S6TX, 8'h80, 8'h80);
    line.tx_take();
    rchk(REG_S6TX, 8'h80, 8'h00);
    wreg(REG_RTLO, 8'h80);
    rxn(5'h02, 1);
    n = s6n;
    line.rx_smf(4'h5);
    settle();
    rchk(REG_S6RX, 8'h1f, 8'h15);
    wreg(REG_RTLO, 8'h90);
    repeat (2) line.rx_smf(4'ha);
    settle();
    rchk(REG_S6RX, 8'h1f, 8'h15);
    line.rx_smf(4'ha);
    settle();
    rchk(REG_S6RX, 8'h1f, 8'h1a);
    compare("sa6 irq", 8'h02, 8'(s6n - n));
    wreg(REG_RTLO, 8'h80);
    wreg(REG_RTHI, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      wreg(REG_FPOL, k == 0 ? 8'hff : 8'h7f);
      rxn(5'h00, 3);
      rchk(REG_RXSA, 8'h1f, 8'h00);
      n = szn;
      rxn(5'h01, 2 - k);
      rchk(REG_RXSA, 8'h1f, 8'h00);
      rxn(5'h01, 1);
      compare("sz irq", 8'h01, 8'(szn - n));
      rchk(REG_RXSA, 8'h1f, 8'h01);
      rchk(REG_RXSA, 8'h1f, 8'h00);
    end
    wreg(REG_RTLO, 8'hc0);
    rxn(5'h00, 3);
    rxn(5'h01, 3);
    rchk(REG_RXSA, 8'h1f, 8'h01);
    rchk(REG_RXSA, 8'h1f, 8'h01);
    wreg(REG_RTLO, 8'h80);
    wreg(REG_FPOL, 8'h7e);
    rchk(REG_RXSA, 8'h1f, 8'h01);
    rxn(5'h00, 2);
    rchk(REG_RXSA, 8'h1f, 8'h01);
    wreg(REG_FPOL, 8'hbf);
    rxn(5'h0b, 3);
    rchk(REG_RXSA, 8'h1f, 8'h0b);
    rchk(REG_RXSA, 8'h1f, 8'h0b);
    wreg(REG_FPOL, 8'h3f);
    rxn(5'h14, 1);
    repeat (60) @(posedge mclk);
    rchk(REG_RXSA, 8'h1f, 8'h14);
    give_verdict();
  end
endmodule : e1_slot0_spare_bit_and_pll_config_bench

// ===== dv/esb_line_model.sv
// partner model: e1 framer strobes and the local multiplex bus
// assumes the block's mclk; mux clock runs free, 256 bits per frame
`timescale 1ns/1ps
module esb_line_model
(
  input  wire logic       mclk,
  output logic            mux_clk,
  output logic            mux_frame,
  output logic            mux_din,
  input  wire logic       mux_dout,
  input  wire logic       mux_dout_oe,
  output logic            rx_sa_strobe,
  output logic [4:0]      rx_sa,
  output logic            rx_smf_strobe,
  output logic [3:0]      rx_sa6,
  output logic            tx_smf_take
);
  logic [7:0] bit_cnt;
  logic [7:0] din_byte;  // din value of slot-zero bit i
  logic [7:0] cap_dout;  // dout seen in slot-zero bit i
  logic [7:0] cap_oe;
  logic [7:0] nxt;
  logic [7:0] prv;
  int         frames;
  assign nxt = bit_cnt + 8'h01;
  assign prv = bit_cnt - 8'h01;
  // quiet bus at time zero, then a free 80 ns bit clock
  initial
  begin
    {mux_clk, mux_frame, mux_din, rx_sa_strobe, rx_smf_strobe, tx_smf_take} = '0;
    {rx_sa, rx_sa6, cap_dout, cap_oe, din_byte} = '0;
    bit_cnt = 8'hfe;
    frames  = 0;
    #3;
    forever #40 mux_clk = ~mux_clk;
  end
  // frame marker and din change on the falling edge, held over the rise
  always @(negedge mux_clk)
  begin
    bit_cnt   <= nxt;
    mux_frame <= (bit_cnt == 8'hff);
    mux_din   <= (nxt < 8'h08) ? din_byte[nxt[2:0]] : ~mux_din;
  end
  // dout of the previous bit still stands at each rising edge
  always @(posedge mux_clk)
  begin
    if (prv < 8'h08)
    begin
      cap_dout[prv[2:0]] <= mux_dout;
      cap_oe[prv[2:0]]   <= mux_dout_oe;
    end
    if (prv == 8'h07)
      frames <= frames + 1;
  end
  // one received frame's spare bits; data lines not held afterwards
  task automatic rx_frame(input logic [4:0] v);
    @(posedge mclk);
    rx_sa        <= v;
    rx_sa_strobe <= 1'b1;
    @(posedge mclk);
    rx_sa_strobe <= 1'b0;
    rx_sa        <= ~v;
    repeat (3) @(posedge mclk);
  endtask : rx_frame
  // one received sub-multiframe nibble
  task automatic rx_smf(input logic [3:0] v);
    @(posedge mclk);
    rx_sa6        <= v;
    rx_smf_strobe <= 1'b1;
    @(posedge mclk);
    rx_smf_strobe <= 1'b0;
    rx_sa6        <= ~v;
    repeat (3) @(posedge mclk);
  endtask : rx_smf
  // framer reports one transmitted nibble
  task automatic tx_take();
    @(posedge mclk);
    tx_smf_take <= 1'b1;
    @(posedge mclk);
    tx_smf_take <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : tx_take
endmodule : esb_line_model

// ===== rtl/esb_pkg.sv
// package of the e1 spare-bit and pll configuration block
// assumes a 100 MHz core clock and an 8-bit register port
package esb_pkg;
  // ********************************
  // register port and offsets
  // ********************************
  localparam int         AW       = 4;
  localparam int         DW       = 8;
  localparam logic [3:0] REG_PLL  = 4'h0;  // pll_and_slot0_control
  localparam logic [3:0] REG_RTLO = 4'h1;  // spare_bit_route_low
  localparam logic [3:0] REG_RTHI = 4'h2;  // spare_bit_route_high
  localparam logic [3:0] REG_FPOL = 4'h3;  // spare_bit_filter_polarity
  localparam logic [3:0] REG_TXSA = 4'h4;  // slot_zero_transmit_data
  localparam logic [3:0] REG_RXSA = 4'h5;  // slot_zero_receive_status
  localparam logic [3:0] REG_S6TX = 4'h6;  // sa6_transmit_register
  localparam logic [3:0] REG_S6RX = 4'h7;  // sa6_receive_register
  localparam logic [7:0] RST_CR   = 8'h80;
  localparam logic [7:0] RST_FP   = 8'hff;
  // ********************************
  // field positions
  // ********************************
  localparam int B_PLL_FREEZE = 0;  // pll_freeze
  localparam int B_CENT = 1;  // crystal_reference_select
  localparam int B_PLL_INPUT_SELECT = 2;  // pll_input_select
  localparam int B_RECOVERED_CLOCK_OUT_DISABLE = 3;  // recovered_clock_out_disable
  localparam int B_NMF  = 4;  // no_multiframe
  localparam int B_APD  = 5;  // output_alarm_pattern
  localparam int B_SLOT_ZERO_OUTPUT_ENABLE = 6;  // slot_zero_output_enable
  localparam int B_SAT  = 4;  // triple_confirm
  localparam int B_OSCILLATOR_DISABLE = 5;  // oscillator_disable
  localparam int B_POL  = 6;  // clear_on_read_policy
  localparam int B_AMI  = 6;  // line_code_select
  localparam int B_SP   = 6;  // single_polarity_mode
  localparam int B_SPARE_BIT_FILTERING = 7;  // spare_bit_filtering
  localparam int B_WT   = 7;  // write_pending_flag
  // ********************************
  // routing codes, slot layout, timing
  // ********************************
  localparam logic [1:0] RT_REG   = 2'b00;
  localparam logic [1:0] RT_PIN   = 2'b01;
  localparam logic [1:0] RT_S6REG = 2'b10;
  localparam logic [1:0] N_THREE  = 2'd3;
  localparam logic [1:0] N_TWO    = 2'd2;
  localparam logic [1:0] N_ONE    = 2'd1;
  localparam logic [7:0] TS0_LEN  = 8'd8;
  localparam logic [2:0] SA_POS   = 3'd3;  // bit 4 of slot zero
  localparam int         CLK_KHZ  = 100000;
  localparam int         STORE_MS = 250;
  localparam int         STORE_CYC = STORE_MS * CLK_KHZ;
endpackage : esb_pkg

// ===== rtl/esb_top.sv
// e1 slot-zero spare-bit routing, filtering and pll configuration
// assumes framer core on mclk; multiplex pins asynchronous to mclk
`timescale 1ns/1ps
module esb_top
#(
  parameter int STORE_CYC = esb_pkg::STORE_CYC
)
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic [esb_pkg::AW-1:0]  addr,
  input  wire logic [esb_pkg::DW-1:0]  wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [esb_pkg::DW-1:0]  rdata,
  input  wire logic                    pll_input_pin,
  input  wire logic                    recovered_clock,
  output logic                         pll_freeze,
  output logic                         pll_ref_crystal,
  output logic                         pll_ref,
  output logic                         recovered_clock_out,
  output logic                         recovered_clock_out_oe,
  output logic                         no_multiframe,
  output logic                         line_code_ami,
  output logic                         oscillator_disable,
  input  wire logic                    mux_clk,
  input  wire logic                    mux_frame,
  input  wire logic                    mux_din,
  input  wire logic                    parallel_host,
  input  wire logic                    payload_bit,
  input  wire logic                    frame_odd,
  input  wire logic                    skip_flag,
  input  wire logic                    slip_flag,
  input  wire logic                    sync_lost,
  input  wire logic                    err_over,
  output logic                         mux_dout,
  output logic                         mux_dout_oe,
  input  wire logic                    rx_sa_strobe,
  input  wire logic [4:0]              rx_sa,
  input  wire logic                    rx_smf_strobe,
  input  wire logic [3:0]              rx_sa6,
  input  wire logic                    tx_smf_take,
  output logic      [4:0]              tx_sa,
  output logic      [3:0]              tx_sa6,
  output logic                         tx_sa6_from_reg,
  output logic                         slot_zero_interrupt,
  output logic                         sa6_interrupt
);
  import esb_pkg::*;

  // route code of spare-bit channel i (sa4..sa8)
  function automatic logic [1:0] route_of(input logic [7:0] lo, input logic [7:0] hi,
                                          input int i);
    logic [1:0] c;
    c = 2'b00;
    case (i)
      0: c = lo[1:0];
      1: c = lo[3:2];
      2: c = hi[1:0];
      3: c = hi[3:2];
      default: c = hi[5:4];
    endcase
    return c;
  endfunction : route_of

  // confirmations needed: three when sel, else alternative
  function automatic logic [1:0] need_of(input logic sel, input logic [1:0] alt);
    return sel ? N_THREE : alt;
  endfunction : need_of

  // ********************************
  // registers
  // ********************************
  logic [7:0] cr_pll;
  logic [7:0] cr_rlo;
  logic [7:0] cr_rhi;
  logic [7:0] cr_fp;
  logic [4:0] txr;
  logic [4:0] rxs;
  logic [3:0] s6tx;
  logic [4:0] s6rx;
  logic       wt;
  logic [1:0] repcnt;
  logic [4:0] cand;
  logic [4:0] acc;
  logic [1:0] cnt [5];
  logic [4:0] last_rx;
  logic [4:0] din_sa;
  logic [4:0] cand6;
  logic [1:0] cnt6;
  logic [31:0] tmr;
  logic [4:0] s1;
  logic [4:0] s2;
  logic       clk_d;
  logic [7:0] bcnt;
  logic       alt;
  logic       next_oe;
  logic       next_dout;
  logic [7:0] next_bcnt;
  logic [4:0] conf;
  logic [4:0] set_v;
  logic [4:0] dest;
  logic [4:0] pin_rt;
  logic [4:0] next_rxs;
  logic [4:0] dsa;
  logic       tick;
  logic       rd_rxs;
  logic       rise;
  logic       ts0;
  logic       par;
  logic       slot_zero_output_enable;
  logic       sp;
  logic       spare_bit_filtering;
  logic       conf6;
  logic [4:0] v6;

  // register writes from the host port
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cr_pll <= RST_CR;
      cr_rlo <= RST_CR;
      cr_rhi <= RST_CR;
      cr_fp  <= RST_FP;
      txr    <= 5'h00;
      s6tx   <= 4'h0;
    end
    else if (wr)
    begin
      case (addr)
        REG_PLL:  cr_pll <= wdata;
        REG_RTLO: cr_rlo <= wdata;
        REG_RTHI: cr_rhi <= wdata;
        REG_FPOL: cr_fp  <= wdata;
        REG_TXSA: txr    <= wdata[4:0];
        REG_S6TX: s6tx   <= wdata[3:0];
        default:  ;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        REG_PLL:  rdata <= cr_pll;
        REG_RTLO: rdata <= cr_rlo;
        REG_RTHI: rdata <= cr_rhi;
        REG_FPOL: rdata <= cr_fp;
        REG_TXSA: rdata <= {3'h0, txr};
        REG_RXSA: rdata <= {3'h0, rxs};
        REG_S6TX: rdata <= {wt, 3'h0, s6tx};
        REG_S6RX: rdata <= {3'h0, s6rx};
        default:  rdata <= 8'h00;
      endcase
    end
  end

  // ********************************
  // pll and line configuration
  // ********************************
  assign pll_freeze         = cr_pll[B_PLL_FREEZE];
  assign pll_ref_crystal    = cr_pll[B_CENT];
  assign no_multiframe      = cr_pll[B_NMF];
  assign line_code_ami      = cr_rhi[B_AMI];
  assign oscillator_disable = cr_rlo[B_OSCILLATOR_DISABLE];

  // pll input source and recovered clock pin
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pll_ref                <= 1'b0;
      recovered_clock_out    <= 1'b0;
      recovered_clock_out_oe <= 1'b0;
    end
    else
    begin
      pll_ref                <= cr_pll[B_PLL_INPUT_SELECT] ? s2[1] : recovered_clock;
      recovered_clock_out    <= recovered_clock;
      recovered_clock_out_oe <= ~cr_pll[B_RECOVERED_CLOCK_OUT_DISABLE];
    end
  end

  chk_pll_freeze: assert property (@(posedge mclk) disable iff (rst)
    wr && addr == REG_PLL |=> pll_freeze == $past(wdata[B_PLL_FREEZE]))
    else $error("pll freeze does not follow register write");
  chk_pll_source: assert property (@(posedge mclk) disable iff (rst)
    cr_pll[B_PLL_INPUT_SELECT] |=> pll_ref == $past(s2[1]))
    else $error("pll input not taken from pin");
  chk_hcr_float: assert property (@(posedge mclk) disable iff (rst)
    wr && addr == REG_PLL && wdata[B_RECOVERED_CLOCK_OUT_DISABLE] |-> ##2 !recovered_clock_out_oe)
    else $error("recovered clock pin still driven");

  // ********************************
  // multiplex pin side
  // ********************************
  assign par  = s2[0];
  assign slot_zero_output_enable = cr_pll[B_SLOT_ZERO_OUTPUT_ENABLE];
  assign rise = s2[4] & ~clk_d;
  assign ts0  = next_bcnt < TS0_LEN;
  assign next_bcnt = s2[3] ? 8'h00 : 8'(bcnt + 8'd1);

  // two-stage synchronisers for pins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1    <= 5'h00;
      s2    <= 5'h00;
      clk_d <= 1'b0;
    end
    else
    begin
      s1    <= {mux_clk, mux_frame, mux_din, pll_input_pin, parallel_host};
      s2    <= s1;
      clk_d <= s2[4];
    end
  end

  // receive bits shown on the output per route
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      pin_rt[i] = route_of(cr_rlo, cr_rhi, i) == RT_PIN;
      dsa[i]    = pin_rt[i] ? last_rx[i] : rxs[i];
    end
  end

  // output bit for the coming multiplex bit
  always_comb
  begin
    next_oe   = 1'b1;
    next_dout = payload_bit;
    if (par && ts0 && !slot_zero_output_enable)
      next_oe = 1'b0;
    if (cr_pll[B_APD])
      next_dout = ~alt;
    else if (slot_zero_output_enable && (sync_lost || err_over))
      next_dout = 1'b1;
    else if (par && ts0 && slot_zero_output_enable)
    begin
      case (next_bcnt[2:0])
        3'd0:    next_dout = frame_odd;
        3'd1:    next_dout = skip_flag;
        3'd2:    next_dout = slip_flag;
        default: next_dout = dsa[3'(next_bcnt[2:0] - SA_POS)];
      endcase
    end
  end

  // bit counter, output bit and input capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bcnt        <= 8'h00;
      alt         <= 1'b0;
      mux_dout    <= 1'b0;
      mux_dout_oe <= 1'b0;
      din_sa      <= 5'h00;
    end
    else if (rise)
    begin
      bcnt        <= next_bcnt;
      alt         <= ~alt;
      mux_dout    <= next_dout;
      mux_dout_oe <= next_oe;
      // din of the bit starting now belongs to count next_bcnt
      if (par && slot_zero_output_enable && ts0 && next_bcnt[2:0] >= SA_POS)
        din_sa[3'(next_bcnt[2:0] - SA_POS)] <= s2[2];
    end
  end

  chk_ts0_float: assert property (@(posedge mclk) disable iff (rst)
    rise && par && ts0 && !slot_zero_output_enable |=> !mux_dout_oe)
    else $error("output driven in slot zero while disabled");
  chk_alarm_ones: assert property (@(posedge mclk) disable iff (rst)
    rise && !cr_pll[B_APD] && slot_zero_output_enable && sync_lost |=> mux_dout)
    else $error("output not forced high on sync loss");

  // ********************************
  // transmit spare bits
  // ********************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_sa           <= 5'h00;
      tx_sa6          <= 4'h0;
      tx_sa6_from_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        tx_sa[i] <= (pin_rt[i] && slot_zero_output_enable) ? din_sa[i] : txr[i];
      tx_sa6          <= s6tx;
      tx_sa6_from_reg <= route_of(cr_rlo, cr_rhi, 2) == RT_S6REG;
    end
  end

  // write pending flag, held until enough sends; a write wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wt     <= 1'b0;
      repcnt <= 2'd0;
    end
    else if (wr && addr == REG_S6TX)
    begin
      wt     <= 1'b1;
      repcnt <= 2'd0;
    end
    else if (wt && tx_smf_take && tx_sa6_from_reg)
    begin
      if (2'(repcnt + N_ONE) == need_of(cr_rlo[B_SAT], N_ONE))
      begin
        wt     <= 1'b0;
        repcnt <= 2'd0;
      end
      else
        repcnt <= 2'(repcnt + N_ONE);
    end
  end

  chk_wt_clear: assert property (@(posedge mclk) disable iff (rst)
    $fell(wt) |-> $past(tx_smf_take) && !$past(wr && addr == REG_S6TX))
    else $error("write pending cleared without a send");

  // ********************************
  // receive spare-bit filtering
  // ********************************
  assign sp     = cr_fp[B_SP];
  assign spare_bit_filtering   = cr_fp[B_SPARE_BIT_FILTERING];
  assign rd_rxs = rd && addr == REG_RXSA;

  // 250ms store timer
  always_ff @(posedge mclk)
  begin
    if (rst || tmr == 32'(STORE_CYC - 1))
      tmr <= 32'h0;
    else
      tmr <= tmr + 32'h1;
  end
  assign tick = tmr == 32'(STORE_CYC - 1);

  // confirmation and set conditions per channel
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      conf[i]  = rx_sa_strobe && rx_sa[i] == cand[i] && cand[i] != acc[i]
               && 2'(cnt[i] + N_ONE) == need_of(spare_bit_filtering, N_TWO);
      set_v[i] = sp && conf[i] && cand[i] == cr_fp[i];
      dest[i]  = i == 2 ? route_of(cr_rlo, cr_rhi, i) != RT_S6REG
                        : route_of(cr_rlo, cr_rhi, i) == RT_REG;
    end
  end

  // next status contents
  always_comb
  begin
    next_rxs = rxs;
    if (sp)
    begin
      if (rd_rxs)
        next_rxs = cr_rlo[B_POL] ? rxs & ~(acc ^ cr_fp[4:0]) : 5'h00;
      next_rxs = next_rxs | (set_v & dest);
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        if (dest[i] && (spare_bit_filtering ? conf[i] : tick))
          next_rxs[i] = spare_bit_filtering ? cand[i] : last_rx[i];
    end
  end

  // per-channel candidate, count and accepted state
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cand    <= 5'h00;
      acc     <= 5'h00;
      last_rx <= 5'h00;
      rxs     <= 5'h00;
      for (int i = 0; i < 5; i++)
        cnt[i] <= 2'd0;
    end
    else
    begin
      rxs <= next_rxs;
      if (rx_sa_strobe)
      begin
        last_rx <= rx_sa;
        for (int i = 0; i < 5; i++)
        begin
          if (rx_sa[i] != cand[i])
          begin
            cand[i] <= rx_sa[i];
            cnt[i]  <= N_ONE;
          end
          else if (cnt[i] != N_THREE)
            cnt[i] <= 2'(cnt[i] + N_ONE);
          if (conf[i])
            acc[i] <= cand[i];
        end
      end
    end
  end

  chk_rx_keep: assert property (@(posedge mclk) disable iff (rst)
    !sp && rd_rxs && !rx_sa_strobe && !tick |=> rxs == $past(rxs))
    else $error("status changed by a read without single polarity");
  chk_sp_set: assert property (@(posedge mclk) disable iff (rst)
    |(set_v & dest) |=> (rxs & $past(set_v & dest)) == $past(set_v & dest))
    else $error("status bit not set on confirmed transition");

  // ********************************
  // sa6 receive register
  // ********************************
  assign v6    = {last_rx[1], rx_sa6};
  assign conf6 = rx_smf_strobe && (cr_rlo[B_SAT]
               ? v6 == cand6 && v6 != s6rx && 2'(cnt6 + N_ONE) == N_THREE
               : 1'b1);

  // sa6 candidate and load
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cand6 <= 5'h00;
      cnt6  <= 2'd0;
      s6rx  <= 5'h00;
    end
    else if (rx_smf_strobe)
    begin
      if (v6 != cand6)
      begin
        cand6 <= v6;
        cnt6  <= N_ONE;
      end
      else if (cnt6 != N_THREE)
        cnt6 <= 2'(cnt6 + N_ONE);
      if (conf6 && route_of(cr_rlo, cr_rhi, 2) == RT_S6REG)
        s6rx <= v6;
    end
  end

  // event pulses
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slot_zero_interrupt <= 1'b0;
      sa6_interrupt       <= 1'b0;
    end
    else
    begin
      slot_zero_interrupt <= |(next_rxs ^ rxs) || |(set_v & dest)
                           || (!sp && !spare_bit_filtering && tick);
      sa6_interrupt       <= conf6 && route_of(cr_rlo, cr_rhi, 2) == RT_S6REG;
    end
  end

  chk_s6_irq: assert property (@(posedge mclk) disable iff (rst)
    sa6_interrupt |-> s6rx == $past(v6))
    else $error("sa6 interrupt without a load");
endmodule : esb_top
